// File: hw/brmc_pkg.sv
// constants and types shared by the buck rail mode control logic
// assumes one 100 MHz clock and an 8-bit register port from the spi slave
package brmc_pkg;

   // register map
   localparam logic [7:0] MEM_CTRL_ADDR    = 8'h37;
   localparam logic [7:0] MEM_CUR_LO_ADDR  = 8'h70;
   localparam logic [7:0] MEM_CUR_HI_ADDR  = 8'h71;
   localparam logic [7:0] R2V1_CUR_LO_ADDR = 8'h72;
   localparam logic [7:0] R2V1_CUR_HI_ADDR = 8'h73;

   // memory_rail_control reset and field layout
   localparam logic [7:0] MEM_CTRL_RESET   = 8'h04;
   localparam int         RUN_LSB          = 0;
   localparam int         EXIT_LSB         = 3;
   localparam int         CTRL_W           = 6;

   // run-mode codes; codes below 4 are reserved or mean no copy
   localparam logic [2:0] CODE_OFF         = 3'h4;
   localparam logic [2:0] CODE_PFM         = 3'h5;
   localparam logic [2:0] CODE_SKIP        = 3'h6;
   localparam logic [2:0] CODE_PWM         = 3'h7;

   // converter result width
   localparam int         ADC_W            = 10;

   typedef enum logic [3:0]
   {
      BRMC_OFF  = 4'h1,
      BRMC_PFM  = 4'h2,
      BRMC_SKIP = 4'h4,
      BRMC_PWM  = 4'h8
   } brmc_mode_e;

   // reserved codes fall back to off so a bad write never runs the rail
   function automatic brmc_mode_e brmc_decode(input logic [2:0] code);
      case (code)
         CODE_PFM:  return BRMC_PFM;
         CODE_SKIP: return BRMC_SKIP;
         CODE_PWM:  return BRMC_PWM;
         default:   return BRMC_OFF;
      endcase
   endfunction

endpackage

// File: hw/brmc_sync.sv
// two-flop synchroniser for a group of asynchronous level inputs
// assumes the inputs are independent levels, no bus coherency needed
`timescale 1ns/1ps
module brmc_sync
#(
   parameter int W = 1
)
(
   input  wire logic         clock,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         meta <= '0;
         q    <= '0;
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// File: hw/brmc_top.sv
// mode control, discharge, fault and current readback
// for the memory rail and the 2.1 v rail, standby exit for the memory rail only
// assumes the spi slave presents single-cycle read/write strobes
`timescale 1ns/1ps
module brmc_top
#(
   parameter int ADC_W = brmc_pkg::ADC_W
)
(
   input  wire logic             clock,
   input  wire logic             nrst,
   input  wire logic [7:0]       reg_addr,
   input  wire logic             reg_wr_en,
   input  wire logic [7:0]       reg_wr_data,
   input  wire logic             reg_rd_en,
   output logic      [7:0]       reg_rd_data,
   input  wire logic             standby_exit_pin,
   input  wire logic             memory_rail_oc,
   input  wire logic             rail_2v1_oc,
   input  wire logic             regulator_shutdown,
   input  wire logic [2:0]       rail_2v1_run_mode,
   input  wire logic [ADC_W-1:0] adc_data,
   input  wire logic             adc_valid,
   input  wire logic             adc_channel,
   output brmc_pkg::brmc_mode_e  memory_rail_mode,
   output logic                  memory_rail_discharge,
   output brmc_pkg::brmc_mode_e  rail_2v1_mode,
   output logic                  rail_2v1_discharge,
   output logic                  memory_rail_fault,
   output logic                  rail_2v1_fault,
   output logic                  regulator_fault_irq
);
   logic [brmc_pkg::CTRL_W-1:0] ctrl;
   logic [brmc_pkg::CTRL_W-1:0] next_ctrl;
   logic [2:0]                  pins_s;
   logic                        exit_s;
   logic                        exit_d;
   logic                        exit_evt;
   logic                        mem_oc_s;
   logic                        r2v1_oc_s;
   logic                        wr_ctrl;
   logic [2:0]                  run_code;
   logic [2:0]                  exit_code;
   brmc_pkg::brmc_mode_e        mem_dec;
   brmc_pkg::brmc_mode_e        r2v1_dec;
   logic [ADC_W-1:0]            mem_cur;
   logic [ADC_W-1:0]            r2v1_cur;
   logic [15:0]                 mem_cur_w;
   logic [15:0]                 r2v1_cur_w;
   logic [7:0]                  next_rd;

   // pins from the analog side and the standby controller are asynchronous
   brmc_sync #(.W(3)) u_sync
   (
      .clock (clock),
      .nrst  (nrst),
      .d     ({standby_exit_pin, memory_rail_oc, rail_2v1_oc}),
      .q     (pins_s)
   );

   assign exit_s    = pins_s[2];
   assign mem_oc_s  = pins_s[1];
   assign r2v1_oc_s = pins_s[0];
   assign run_code  = ctrl[brmc_pkg::RUN_LSB +: 3];
   assign exit_code = ctrl[brmc_pkg::EXIT_LSB +: 3];
   assign mem_dec   = brmc_pkg::brmc_decode(run_code);
   assign r2v1_dec  = brmc_pkg::brmc_decode(rail_2v1_run_mode);
   assign wr_ctrl   = reg_wr_en && (reg_addr == brmc_pkg::MEM_CTRL_ADDR);

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         exit_d <= 1'b0;
      else
         exit_d <= exit_s;
   end

   // one copy per assertion of the pin, not a continuous override
   assign exit_evt = exit_s && !exit_d;

   // the exit copy beats a same-cycle host write of the run field
   always_comb
   begin
      next_ctrl = ctrl;
      if (wr_ctrl)
         next_ctrl = reg_wr_data[brmc_pkg::CTRL_W-1:0];
      if (exit_evt && exit_code[2])
         next_ctrl[brmc_pkg::RUN_LSB +: 3] = exit_code;
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         ctrl <= brmc_pkg::MEM_CTRL_RESET[brmc_pkg::CTRL_W-1:0];
      else
         ctrl <= next_ctrl;
   end

   // mode decode and discharge; reserved codes count as off
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         memory_rail_mode      <= brmc_pkg::BRMC_OFF;
         rail_2v1_mode         <= brmc_pkg::BRMC_OFF;
         memory_rail_discharge <= 1'b1;
         rail_2v1_discharge    <= 1'b1;
      end
      else
      begin
         memory_rail_mode      <= mem_dec;
         rail_2v1_mode         <= r2v1_dec;
         memory_rail_discharge <= regulator_shutdown ||
            (mem_dec == brmc_pkg::BRMC_OFF);
         rail_2v1_discharge    <= regulator_shutdown ||
            (r2v1_dec == brmc_pkg::BRMC_OFF);
      end
   end

   // faults are levels; the analog side already limits current per cycle
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         memory_rail_fault   <= 1'b0;
         rail_2v1_fault      <= 1'b0;
         regulator_fault_irq <= 1'b0;
      end
      else
      begin
         memory_rail_fault   <= mem_oc_s;
         rail_2v1_fault      <= r2v1_oc_s;
         regulator_fault_irq <= mem_oc_s || r2v1_oc_s;
      end
   end

   // current results land whole, so the two halves of one read agree
   // only if the host reads them between conversions
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         mem_cur <= '0;
         r2v1_cur <= '0;
      end
      else if (adc_valid)
      begin
         if (!adc_channel)
            mem_cur <= adc_data;
         else
            r2v1_cur <= adc_data;
      end
   end

   assign mem_cur_w = 16'(mem_cur);
   assign r2v1_cur_w = 16'(r2v1_cur);

   always_comb
   begin
      case (reg_addr)
         brmc_pkg::MEM_CTRL_ADDR:   next_rd = {2'h0, ctrl};
         brmc_pkg::MEM_CUR_LO_ADDR: next_rd = mem_cur_w[7:0];
         brmc_pkg::MEM_CUR_HI_ADDR: next_rd = mem_cur_w[15:8];
         brmc_pkg::R2V1_CUR_LO_ADDR: next_rd = r2v1_cur_w[7:0];
         brmc_pkg::R2V1_CUR_HI_ADDR: next_rd = r2v1_cur_w[15:8];
         default:                   next_rd = 8'h00;
      endcase
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         reg_rd_data <= 8'h00;
      else if (reg_rd_en)
         reg_rd_data <= next_rd;
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   a_run_decode: assert property (
      ##1 memory_rail_mode == brmc_pkg::brmc_decode($past(run_code)))
      else $error("memory rail mode does not follow run field");

   a_exit_copy: assert property (
      exit_evt && exit_code[2] |=> run_code == $past(exit_code))
      else $error("standby exit did not copy exit mode");

   a_exit_keep: assert property (
      exit_evt && !exit_code[2] && !wr_ctrl |=> $stable(run_code))
      else $error("no-copy exit code changed run mode");

   a_ctrl_read: assert property (
      reg_rd_en && reg_addr == brmc_pkg::MEM_CTRL_ADDR
      |=> reg_rd_data == {2'h0, $past(ctrl)})
      else $error("control register read back wrong");

   a_host_write: assert property (
      wr_ctrl && !exit_evt |=> ##1 memory_rail_mode
         == brmc_pkg::brmc_decode($past(reg_wr_data[2:0], 2)))
      else $error("host mode write not applied in two cycles");

   // two sync flops plus the fault flop: visible one edge after three highs
   a_mem_fault: assert property (
      memory_rail_oc [*3] |=> memory_rail_fault && regulator_fault_irq)
      else $error("memory rail over-current not reported");

   a_r2v1_fault: assert property (
      rail_2v1_oc [*3] |=> rail_2v1_fault && regulator_fault_irq)
      else $error("2.1 v rail over-current not reported");

   a_off_discharge: assert property (
      memory_rail_mode == brmc_pkg::BRMC_OFF |-> memory_rail_discharge)
      else $error("memory rail off without discharge");

   a_cur_capture: assert property (
      adc_valid && adc_channel |=> r2v1_cur == $past(adc_data))
      else $error("2.1 v rail current not captured");

   a_irq_or: assert property (
      regulator_fault_irq == (memory_rail_fault || rail_2v1_fault))
      else $error("fault interrupt is not the or of rail faults");

endmodule

// File: tb/brmc_host.sv
// host model of the spi slave's register port, single-cycle strobes
// assumes the bench owns the clock and calls wr and rd by hierarchy
`timescale 1ns/1ps
module brmc_host
(
   input  wire logic       clock,
   input  wire logic [7:0] reg_rd_data,
   output logic      [7:0] reg_addr,
   output logic            reg_wr_en,
   output logic      [7:0] reg_wr_data,
   output logic            reg_rd_en
);
   initial
   begin
      reg_addr = 8'h00;
      reg_wr_en = 1'b0;
      reg_wr_data = 8'h00;
      reg_rd_en = 1'b0;
   end
   // idle lines flip so a stale value is never mistaken for a request
   task automatic idle();
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = ~reg_addr;
      reg_wr_data = ~reg_wr_data;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      #1;
      reg_addr = a;
      reg_wr_data = d;
      reg_wr_en = 1'b1;
      @(posedge clock);
      #1;
      idle();
   endtask
   // waits one edge past the strobe since the data is registered
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      #1;
      reg_addr = a;
      reg_rd_en = 1'b1;
      @(posedge clock);
      #1;
      idle();
      @(posedge clock);
      #1;
      d = reg_rd_data;
   endtask
endmodule

// File: tb/tb.sv
// self-checking bench for the buck rail mode control block
// assumes brmc_pkg and brmc_top compiled first, host model alongside
`timescale 1ns/1ps
module tb;
   logic                 clock = 1'b0;
   logic                 nrst = 1'b0;
   logic [7:0]           reg_addr, reg_wr_data, reg_rd_data, rd;
   logic                 reg_wr_en, reg_rd_en;
   logic                 standby_exit_pin = 1'b0;
   logic                 memory_rail_oc = 1'b0;
   logic                 rail_2v1_oc = 1'b0;
   logic                 regulator_shutdown = 1'b0;
   logic [2:0]           rail_2v1_run_mode = 3'h4;
   logic [9:0]           adc_data = 10'h000;
   logic                 adc_valid = 1'b0;
   logic                 adc_channel = 1'b0;
   brmc_pkg::brmc_mode_e memory_rail_mode, rail_2v1_mode;
   logic                 memory_rail_discharge, rail_2v1_discharge;
   logic                 memory_rail_fault, rail_2v1_fault;
   logic                 regulator_fault_irq;
   int                   num_errors = 0;
   int                   check_count = 0;
   int                   cycles = 0;
   // rows: write data, expected one-hot mode, expected discharge
   logic [12:0] rows [8] = '{{8'h00, 4'h1, 1'b1}, {8'h09, 4'h1, 1'b1},
      {8'h12, 4'h1, 1'b1}, {8'h1b, 4'h1, 1'b1}, {8'h04, 4'h1, 1'b1},
      {8'h0d, 4'h2, 1'b0}, {8'h16, 4'h4, 1'b0}, {8'hdf, 4'h8, 1'b0}};
   logic [7:0] cur [4] = '{8'hff, 8'h03, 8'h55, 8'h01};

   always #5 clock = ~clock;

   brmc_host host (.clock, .reg_rd_data, .reg_addr, .reg_wr_en,
      .reg_wr_data, .reg_rd_en);
   brmc_top #(.ADC_W(10)) dut (.clock, .nrst, .reg_addr, .reg_wr_en,
      .reg_wr_data, .reg_rd_en, .reg_rd_data, .standby_exit_pin,
      .memory_rail_oc, .rail_2v1_oc, .regulator_shutdown,
      .rail_2v1_run_mode, .adc_data, .adc_valid, .adc_channel,
      .memory_rail_mode, .memory_rail_discharge, .rail_2v1_mode,
      .rail_2v1_discharge, .memory_rail_fault, .rail_2v1_fault,
      .regulator_fault_irq);

   task automatic results();
      if (num_errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic rst_chk();
      nrst = 1'b0;
      tick(3);
      nrst = 1'b1;
      tick(2);
      host.rd(8'h37, rd);
      cmp(rd, 8'h04);
      cmp(memory_rail_mode, 8'h01);
      cmp(memory_rail_discharge, 8'h01);
      cmp(regulator_fault_irq, 8'h00);
   endtask

   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         num_errors++;
         results();
      end
   end

   initial
   begin
      rst_chk();
      foreach (rows[i])
      begin
         host.wr(8'h37, rows[i][12:5]);
         tick(3);
         cmp(memory_rail_mode, rows[i][4:1]);
         cmp(memory_rail_discharge, rows[i][0]);
         host.rd(8'h37, rd);
         cmp(rd, rows[i][12:5] & 8'h3f);
      end
      host.wr(8'h37, 8'h3d);
      standby_exit_pin = 1'b1;
      tick(6);
      cmp(memory_rail_mode, 8'h08);
      host.rd(8'h37, rd);
      cmp(rd, 8'h3f);
      // pin still high: a fresh run code must not be overwritten again
      host.wr(8'h37, 8'h3d);
      tick(6);
      cmp(memory_rail_mode, 8'h02);
      standby_exit_pin = 1'b0;
      host.wr(8'h37, 8'h16);
      tick(3);
      standby_exit_pin = 1'b1;
      tick(6);
      cmp(memory_rail_mode, 8'h04);
      standby_exit_pin = 1'b0;
      host.wr(8'h38, 8'h07);
      host.rd(8'h37, rd);
      cmp(rd, 8'h16);
      host.rd(8'h55, rd);
      cmp(rd, 8'h00);
      memory_rail_oc = 1'b1;
      tick(4);
      cmp({memory_rail_fault, rail_2v1_fault}, 8'h02);
      cmp(regulator_fault_irq, 8'h01);
      memory_rail_oc = 1'b0;
      rail_2v1_oc = 1'b1;
      tick(4);
      cmp({memory_rail_fault, rail_2v1_fault}, 8'h01);
      cmp(regulator_fault_irq, 8'h01);
      rail_2v1_oc = 1'b0;
      tick(4);
      cmp(regulator_fault_irq, 8'h00);
      rail_2v1_run_mode = 3'h6;
      tick(3);
      cmp(rail_2v1_mode, 8'h04);
      cmp(rail_2v1_discharge, 8'h00);
      regulator_shutdown = 1'b1;
      tick(3);
      cmp({memory_rail_discharge, rail_2v1_discharge}, 8'h03);
      regulator_shutdown = 1'b0;
      rail_2v1_run_mode = 3'h7;
      tick(3);
      cmp(rail_2v1_mode, 8'h08);
      rail_2v1_run_mode = 3'h5;
      tick(3);
      cmp(rail_2v1_mode, 8'h02);
      adc_valid = 1'b1;
      adc_data = 10'h3ff;
      tick(1);
      adc_channel = 1'b1;
      adc_data = 10'h155;
      tick(1);
      adc_valid = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         host.rd(8'h70 + 8'(i), rd);
         cmp(rd, cur[i]);
      end
      rst_chk();
      results();
   end
endmodule
